// File: rtl/obp_regs.vh
// Timing and field constants for the OTP byte program sequencer
`ifndef OBP_REGS_VH
`define OBP_REGS_VH
`define OBP_CLK_NS 100
`define OBP_PW_MIN_NS 95000
`define OBP_PW_MAX_NS 105000
`define OBP_PW_NOM_NS 100000
`define OBP_PW_CYC ((`OBP_PW_NOM_NS + `OBP_CLK_NS - 1) / `OBP_CLK_NS)
`define OBP_SETUP_NS 2000
`define OBP_SETUP_CYC ((`OBP_SETUP_NS + `OBP_CLK_NS - 1) / `OBP_CLK_NS)
`define OBP_TOE_NS 150
`define OBP_TOE_CYC ((`OBP_TOE_NS + `OBP_CLK_NS - 1) / `OBP_CLK_NS)
`define OBP_TDFP_NS 130
`define OBP_TDFP_CYC ((`OBP_TDFP_NS + `OBP_CLK_NS - 1) / `OBP_CLK_NS)
`define OBP_SUPPLY_NS 100000
`define OBP_SUPPLY_CYC ((`OBP_SUPPLY_NS + `OBP_CLK_NS - 1) / `OBP_CLK_NS)
`define OBP_RETRY_MAX 10
`define OBP_ADDR_W 19
`define OBP_LAST_ADDR 19'h7ffff
`define OBP_RES_NONE 2'h0
`define OBP_RES_PASS 2'h1
`define OBP_RES_FAIL 2'h2
`endif

// File: rtl/obp_sequencer.v
// Programmer-side sequencer for a 512K x 8 OTP memory
// Notes on behaviour
// - Program strobe low for 100 us, 95..105.
// - Start programming at the first address.
// - Raise supplies to program levels before pulsing.
// - First pass: one pulse per address, no verify.
// - Then verify and reprogram each address in turn.
// - On failure, up to ten pulses, verify each.
// - Still failing after ten pulses: part failed.
// - On good verify, advance until all checked.
// - Then nominal supplies, read back, compare all.
// - Core supply up first and down last.
// - Identification mode holds address pin nine high.
`timescale 1ns/10ps
`default_nettype none
`include "obp_regs.vh"
module obp_sequencer #(
   parameter PW_CYC = `OBP_PW_CYC,
   parameter SUPPLY_CYC = `OBP_SUPPLY_CYC,
   parameter [18:0] LAST_ADDR = `OBP_LAST_ADDR
) (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire start_prog_i,
   input wire start_id_i,
   input wire [7:0] src_data_i,
   input wire [7:0] data_pins_i,
   input wire rd_ready_i,
   output reg [18:0] addr_o,
   output reg [7:0] data_pins_o,
   output reg data_pins_oe_o,
   output reg prog_strobe_n_o,
   output reg out_gate_n_o,
   output reg core_hi_o,
   output reg prog_hi_o,
   output reg prog_en_o,
   output reg id_mode_address_pin_o,
   output reg [18:0] src_addr_o,
   output reg busy_o,
   output reg [1:0] result_o,
   output reg [7:0] rd_data_o,
   output reg rd_valid_o,
   output reg [7:0] mfr_code_o,
   output reg [7:0] dev_code_o
);
   localparam ST_IDLE = 4'd0;
   localparam ST_PWR_UP = 4'd1;
   localparam ST_SETUP = 4'd2;
   localparam ST_PULSE = 4'd3;
   localparam ST_HOLD = 4'd4;
   localparam ST_RD_GATE = 4'd5;
   localparam ST_RD_SAMPLE = 4'd6;
   localparam ST_PWR_DN = 4'd7;
   localparam ST_DONE = 4'd8;
   localparam ST_ID_RD = 4'd9;
   localparam PH_FIRST = 2'd0;
   localparam PH_VERIFY = 2'd1;
   localparam PH_FINAL = 2'd2;
   localparam PH_ID = 2'd3;
   localparam integer SETUP_I = `OBP_SETUP_CYC;
   localparam integer TOE_I = `OBP_TOE_CYC + 1;
   localparam integer TDFP_I = `OBP_TDFP_CYC;
   localparam integer RETRY_I = `OBP_RETRY_MAX;
   localparam [16:0] C_SETUP = SETUP_I[16:0];
   localparam [16:0] C_TOE = TOE_I[16:0];
   localparam [16:0] C_TDFP = TDFP_I[16:0];
   localparam [3:0] C_RETRY = RETRY_I[3:0];

   reg [3:0] st_q;
   reg [1:0] ph_q;
   reg [16:0] cnt_q;
   reg [3:0] try_q;
   reg dn_step_q;
   // Two-entry skid buffer so a stalled reader loses no byte
   reg [7:0] buf_q [0:1];
   reg [1:0] buf_n_q;
   reg buf_wp_q;
   reg buf_rp_q;
   wire buf_ready;
   wire push;
   wire pop;
   wire cnt_done;

   function last_is;
      input [18:0] a;
      input [18:0] l;
      begin
         last_is = (a == l);
      end
   endfunction

   assign cnt_done = (cnt_q == 17'h00000);
   assign buf_ready = (buf_n_q != 2'h2);
   assign pop = rd_valid_o && rd_ready_i;
   assign push = (st_q == ST_RD_SAMPLE) && cnt_done && (ph_q == PH_FINAL) && buf_ready;

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         st_q <= ST_IDLE;
         ph_q <= PH_FIRST;
         cnt_q <= 17'h00000;
         try_q <= 4'h0;
         dn_step_q <= 1'b0;
         addr_o <= 19'h00000;
         src_addr_o <= 19'h00000;
         data_pins_o <= 8'h00;
         data_pins_oe_o <= 1'b0;
         prog_strobe_n_o <= 1'b1;
         out_gate_n_o <= 1'b1;
         core_hi_o <= 1'b0;
         prog_hi_o <= 1'b0;
         prog_en_o <= 1'b0;
         id_mode_address_pin_o <= 1'b0;
         busy_o <= 1'b0;
         result_o <= `OBP_RES_NONE;
         mfr_code_o <= 8'h00;
         dev_code_o <= 8'h00;
      end else begin
         if (!cnt_done) begin
            cnt_q <= cnt_q - 17'h00001;
         end
         case (st_q)
            ST_IDLE: begin
               if (start_prog_i) begin
                  addr_o <= 19'h00000;
                  src_addr_o <= 19'h00000;
                  ph_q <= PH_FIRST;
                  busy_o <= 1'b1;
                  result_o <= `OBP_RES_NONE;
                  core_hi_o <= 1'b1;
                  prog_en_o <= 1'b1;
                  dn_step_q <= 1'b0;
                  cnt_q <= SUPPLY_CYC[16:0];
                  st_q <= ST_PWR_UP;
               end else if (start_id_i) begin
                  ph_q <= PH_ID;
                  busy_o <= 1'b1;
                  id_mode_address_pin_o <= 1'b1;
                  addr_o <= 19'h00000;
                  cnt_q <= C_SETUP;
                  st_q <= ST_RD_GATE;
               end
            end
            ST_PWR_UP: begin
               // Programming supply only after the core supply has settled
               if (cnt_done) begin
                  prog_hi_o <= 1'b1;
                  cnt_q <= SUPPLY_CYC[16:0];
                  st_q <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               data_pins_o <= src_data_i;
               out_gate_n_o <= 1'b1;
               // Drive only once the memory has let go, then count full data setup
               if (!data_pins_oe_o) begin
                  if (cnt_done) begin
                     data_pins_oe_o <= 1'b1;
                     cnt_q <= C_SETUP;
                  end
               end else if (cnt_done) begin
                  prog_strobe_n_o <= 1'b0;
                  cnt_q <= PW_CYC[16:0] - 17'h00001;
                  st_q <= ST_PULSE;
               end
            end
            ST_PULSE: begin
               if (cnt_done) begin
                  prog_strobe_n_o <= 1'b1;
                  cnt_q <= C_SETUP;
                  st_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt_done) begin
                  data_pins_oe_o <= 1'b0;
                  if (ph_q == PH_FIRST) begin
                     if (last_is(addr_o, LAST_ADDR)) begin
                        ph_q <= PH_VERIFY;
                        addr_o <= 19'h00000;
                        src_addr_o <= 19'h00000;
                        try_q <= 4'h0;
                        cnt_q <= C_SETUP;
                        st_q <= ST_RD_GATE;
                     end else begin
                        addr_o <= addr_o + 19'h00001;
                        src_addr_o <= addr_o + 19'h00001;
                        cnt_q <= C_SETUP;
                        st_q <= ST_SETUP;
                     end
                  end else begin
                     try_q <= try_q + 4'h1;
                     cnt_q <= C_SETUP;
                     st_q <= ST_RD_GATE;
                  end
               end
            end
            ST_RD_GATE: begin
               // Data pins already released; gate on once the loaded wait (setup, float time or supply settle) ends
               if (cnt_done) begin
                  out_gate_n_o <= 1'b0;
                  cnt_q <= C_TOE;
                  st_q <= ST_RD_SAMPLE;
               end
            end
            ST_RD_SAMPLE: begin
               if (cnt_done && (ph_q != PH_FINAL || buf_ready)) begin
                  out_gate_n_o <= 1'b1;
                  cnt_q <= C_TDFP;
                  st_q <= ST_RD_GATE;
                  case (ph_q)
                     PH_ID: begin
                        if (!addr_o[0]) begin
                           mfr_code_o <= data_pins_i;
                           addr_o <= 19'h00001;
                        end else begin
                           dev_code_o <= data_pins_i;
                           id_mode_address_pin_o <= 1'b0;
                           addr_o <= 19'h00000;
                           st_q <= ST_DONE;
                        end
                     end
                     PH_VERIFY: begin
                        if (data_pins_i == src_data_i) begin
                           try_q <= 4'h0;
                           if (last_is(addr_o, LAST_ADDR)) begin
                              dn_step_q <= 1'b0;
                              cnt_q <= SUPPLY_CYC[16:0];
                              st_q <= ST_PWR_DN;
                           end else begin
                              addr_o <= addr_o + 19'h00001;
                              src_addr_o <= addr_o + 19'h00001;
                           end
                        end else if (try_q == C_RETRY) begin
                           result_o <= `OBP_RES_FAIL;
                           dn_step_q <= 1'b0;
                           cnt_q <= SUPPLY_CYC[16:0];
                           st_q <= ST_PWR_DN;
                        end else begin
                           st_q <= ST_SETUP;
                        end
                     end
                     PH_FINAL: begin
                        if (data_pins_i != src_data_i) begin
                           result_o <= `OBP_RES_FAIL;
                        end
                        if (last_is(addr_o, LAST_ADDR)) begin
                           // The last byte's own compare must count too
                           if ((result_o == `OBP_RES_NONE) && (data_pins_i == src_data_i)) begin
                              result_o <= `OBP_RES_PASS;
                           end
                           st_q <= ST_DONE;
                        end else begin
                           addr_o <= addr_o + 19'h00001;
                           src_addr_o <= addr_o + 19'h00001;
                        end
                     end
                     default: st_q <= ST_DONE;
                  endcase
               end
            end
            ST_PWR_DN: begin
               // Programming supply drops first, core supply after
               if (cnt_done) begin
                  if (!dn_step_q) begin
                     prog_hi_o <= 1'b0;
                     dn_step_q <= 1'b1;
                     cnt_q <= SUPPLY_CYC[16:0];
                  end else begin
                     core_hi_o <= 1'b0;
                     prog_en_o <= 1'b0;
                     if (result_o == `OBP_RES_FAIL) begin
                        st_q <= ST_DONE;
                     end else begin
                        ph_q <= PH_FINAL;
                        addr_o <= 19'h00000;
                        src_addr_o <= 19'h00000;
                        cnt_q <= SUPPLY_CYC[16:0];
                        st_q <= ST_RD_GATE;
                     end
                  end
               end
            end
            ST_DONE: begin
               if (cnt_done) begin
                  busy_o <= 1'b0;
                  st_q <= ST_IDLE;
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         buf_n_q <= 2'h0;
         buf_wp_q <= 1'b0;
         buf_rp_q <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= 8'h00;
      end else begin
         if (push) begin
            buf_q[buf_wp_q] <= data_pins_i;
            buf_wp_q <= ~buf_wp_q;
         end
         if (pop) begin
            buf_rp_q <= ~buf_rp_q;
         end
         buf_n_q <= buf_n_q + {1'b0, push} - {1'b0, pop};
         if (!rd_valid_o || pop) begin
            if (buf_n_q != 2'h0 && !(pop && buf_n_q == 2'h1)) begin
               rd_data_o <= pop ? buf_q[~buf_rp_q] : buf_q[buf_rp_q];
               rd_valid_o <= 1'b1;
            end else if (push) begin
               rd_data_o <= data_pins_i;
               rd_valid_o <= 1'b1;
            end else begin
               rd_valid_o <= 1'b0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: verification/obp_seq_monitor.sv
// Port checker for the OTP byte program sequencer
`timescale 1ns/10ps
`default_nettype none
`include "obp_regs.vh"
module obp_seq_monitor #(
   parameter PW_CYC = 1000
) (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire start_prog_i,
   input wire start_id_i,
   input wire [18:0] addr_o,
   input wire data_pins_oe_o,
   input wire prog_strobe_n_o,
   input wire out_gate_n_o,
   input wire core_hi_o,
   input wire prog_hi_o,
   input wire prog_en_o,
   input wire id_mode_address_pin_o,
   input wire busy_o,
   input wire rd_valid_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   logic [15:0] low_cnt_q;
   logic [3:0] hit_cnt_q;
   logic [18:0] addr_prev_q;
   logic strb_prev_q;
   logic [7:0] oe_cnt_q;
   // Pulses are counted per address; a new address starts the count afresh
   always @(posedge clk_sys_i) begin
      addr_prev_q <= addr_o;
      strb_prev_q <= prog_strobe_n_o;
      oe_cnt_q <= (sys_rst_i || !data_pins_oe_o) ? 8'h0 :
         ((oe_cnt_q == 8'hff) ? oe_cnt_q : oe_cnt_q + 8'h1);
      low_cnt_q <= (sys_rst_i || prog_strobe_n_o) ? 16'h0 : low_cnt_q + 16'h1;
      hit_cnt_q <= (sys_rst_i || addr_o != addr_prev_q) ? 4'h0 :
         hit_cnt_q + {3'h0, strb_prev_q & ~prog_strobe_n_o};
   end
   sequence s_core_up;
      $rose(core_hi_o);
   endsequence
   sequence s_prog_wait;
      !prog_hi_o [*8];
   endsequence
   a_pulse_width: assert property ($rose(prog_strobe_n_o) |-> low_cnt_q == PW_CYC)
      else $error("Program strobe width wrong");
   a_supply_gap: assert property (s_core_up |-> s_prog_wait)
      else $error("Programming supply rose too soon");
   a_core_first: assert property ($rose(prog_hi_o) |-> core_hi_o)
      else $error("Programming supply up before core");
   a_core_last: assert property ($fell(core_hi_o) |-> !prog_hi_o)
      else $error("Core supply down before programming supply");
   a_pulse_cond: assert property (!prog_strobe_n_o |-> core_hi_o && prog_hi_o)
      else $error("Pulse without elevated supplies");
   a_pulse_drive: assert property (!prog_strobe_n_o |-> data_pins_oe_o && out_gate_n_o)
      else $error("Data not driven or gate active in pulse");
   a_data_setup: assert property ($fell(prog_strobe_n_o) |-> oe_cnt_q >= `OBP_SETUP_CYC)
      else $error("Data setup before pulse too short");
   a_gate_release: assert property (!out_gate_n_o |-> !data_pins_oe_o)
      else $error("Data driven while gate active");
   a_start_addr: assert property ($rose(prog_hi_o) |-> addr_o == 19'h0)
      else $error("Programming not started at first address");
   a_retry_limit: assert property (hit_cnt_q <= `OBP_RETRY_MAX + 1)
      else $error("Too many pulses on one address");
   a_readback_nom: assert property (rd_valid_o |-> !core_hi_o && !prog_hi_o)
      else $error("Readback at elevated supply");
   a_id_quiet: assert property (id_mode_address_pin_o |-> prog_strobe_n_o && !prog_en_o)
      else $error("Pulse or supply during identification");
   a_start_busy: assert property ((start_prog_i || start_id_i) && !busy_o |=> busy_o)
      else $error("Start not taken");
endmodule
`default_nettype wire

// File: verification/obp_otp_model.sv
// Behavioural model of the OTP memory driven by the sequencer
`timescale 1ns/10ps
`default_nettype none
module obp_otp_model #(
   parameter [7:0] MFR_CODE = 8'h5a, // Arbitrary value
   parameter [7:0] DEV_CODE = 8'ha7 // Arbitrary value
) (
   input wire logic clear_i,
   input wire logic [1:0] weak_addr_i,
   input wire logic [3:0] weak_need_i,
   input wire logic [18:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic prog_strobe_n_i,
   input wire logic out_gate_n_i,
   input wire logic core_hi_i,
   input wire logic prog_hi_i,
   input wire logic id_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   output int bad_pulse_o
);
   logic [7:0] mem [0:3];
   logic [3:0] hits [0:3];
   logic [1:0] pa;
   realtime fall_t = -1.0;
   realtime w;
   initial bad_pulse_o = 0;
   always @(posedge clear_i) begin
      for (int i = 0; i < 4; i++) begin
         mem[i] = 8'hff;
         hits[i] = 4'h0;
      end
   end
   always @(negedge prog_strobe_n_i) fall_t = $realtime;
   // A weak byte only takes after weak_need_i pulses, to force retries
   always @(posedge prog_strobe_n_i) begin
      w = $realtime - fall_t;
      pa = addr_i[1:0];
      if (fall_t >= 0.0) begin
         if (w < 95000.0 || w > 105000.0 || !core_hi_i || !prog_hi_i) begin
            bad_pulse_o = bad_pulse_o + 1;
         end else begin
            hits[pa] = hits[pa] + 4'h1;
            if (pa != weak_addr_i || hits[pa] >= weak_need_i)
               mem[pa] = mem[pa] & data_i;
         end
      end
   end
   assign data_oe_o = !out_gate_n_i && prog_strobe_n_i;
   assign data_o = id_i ? (addr_i[0] ? DEV_CODE : MFR_CODE) : mem[addr_i[1:0]];
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the OTP byte program sequencer
`timescale 1ns/10ps
`default_nettype none
`include "obp_regs.vh"
module tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic start_prog = 1'b0;
   logic start_id = 1'b0;
   logic rd_ready = 1'b0;
   logic clear = 1'b0;
   logic [1:0] weak_addr = 2'h0;
   logic [3:0] weak_need = 4'h1;
   logic [7:0] src [0:3];
   logic [7:0] last_q = 8'h00;
   logic [7:0] rd_q [$];
   wire [18:0] addr, src_addr;
   wire [7:0] pins_o, pins_i, m_q, rd_data, mfr, dev;
   wire oe, strb_n, gate_n, core_hi, prog_hi, prog_en, id_pin, busy, rd_valid, m_oe;
   wire [1:0] result;
   int fail_count = 0, checked = 0, cycles = 0, pulses = 0, reads = 0, early = 0, stall = 0;
   int bad_pulse;
   // An undriven bus shows the inverse of its last level, never a lucky match
   assign pins_i = oe ? pins_o : (m_oe ? m_q : ~last_q);
   obp_sequencer #(.SUPPLY_CYC(10), .LAST_ADDR(19'h3)) dut (.clk_sys_i(clk), .sys_rst_i(rst),
      .start_prog_i(start_prog), .start_id_i(start_id), .src_data_i(src[src_addr[1:0]]),
      .data_pins_i(pins_i), .rd_ready_i(rd_ready), .addr_o(addr), .data_pins_o(pins_o),
      .data_pins_oe_o(oe), .prog_strobe_n_o(strb_n), .out_gate_n_o(gate_n),
      .core_hi_o(core_hi), .prog_hi_o(prog_hi), .prog_en_o(prog_en),
      .id_mode_address_pin_o(id_pin), .src_addr_o(src_addr), .busy_o(busy),
      .result_o(result), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .mfr_code_o(mfr),
      .dev_code_o(dev));
   obp_otp_model mem (.clear_i(clear), .weak_addr_i(weak_addr), .weak_need_i(weak_need),
      .addr_i(addr), .data_i(pins_i), .prog_strobe_n_i(strb_n), .out_gate_n_i(gate_n),
      .core_hi_i(core_hi), .prog_hi_i(prog_hi), .id_i(id_pin), .data_o(m_q),
      .data_oe_o(m_oe), .bad_pulse_o(bad_pulse));
   initial forever #50 clk = ~clk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      last_q <= pins_i;
      if (rd_valid && rd_ready)
         rd_q.push_back(rd_data);
      if (cycles == 60000) begin
         fail_count++;
         print_verdict();
      end
   end
   // Readback is stalled for a while so the buffer fills and refuses
   always @(negedge clk) begin
      if (rd_valid && stall > 0)
         stall <= stall - 1;
      rd_ready <= (stall == 0) && ($urandom % 4 != 0);
   end
   always @(negedge strb_n) begin
      if (pulses < 4)
         check({13'h0, addr}, pulses);
      pulses++;
   end
   always @(negedge gate_n) begin
      if (core_hi === 1'b1) begin
         reads++;
         if (pulses < 4)
            early++;
      end
   end
   task automatic start(input logic prog);
      @(negedge clk);
      start_prog = prog;
      start_id = !prog;
      @(negedge clk);
      start_prog = 1'b0;
      start_id = 1'b0;
      clear = 1'b0;
      @(negedge clk);
      check(busy, 1'b1);
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 40000) begin
         @(negedge clk);
         n++;
      end
      check(busy, 1'b0);
   endtask
   // Four addresses here; a byte that never takes ends the run at its address
   function automatic int exp_pulses(input logic [3:0] need);
      return (need > `OBP_RETRY_MAX + 1) ? 4 + `OBP_RETRY_MAX : 3 + need;
   endfunction
   function automatic int exp_reads(input logic [3:0] need, input logic [1:0] wa);
      return (need > `OBP_RETRY_MAX + 1) ? wa + `OBP_RETRY_MAX + 1 : 3 + need;
   endfunction
   task automatic run_prog(input logic [3:0] need);
      pulses = 0;
      reads = 0;
      early = 0;
      stall = 50;
      rd_q.delete();
      for (int i = 0; i < 4; i++)
         src[i] = 8'($urandom);
      weak_addr = 2'($urandom);
      weak_need = need;
      src[weak_addr] = src[weak_addr] & 8'hfe;
      clear = 1'b1;
      start(1'b1);
      repeat (100) @(negedge clk);
      start_id = 1'b1;
      @(negedge clk);
      start_id = 1'b0;
      wait_idle();
      check(result, need > 11 ? `OBP_RES_FAIL : `OBP_RES_PASS);
      check(pulses, exp_pulses(need));
      check(reads, exp_reads(need, weak_addr));
      check(early, 0);
      check(rd_q.size(), need > 11 ? 0 : 4);
      foreach (rd_q[i])
         check(rd_q[i], src[i]);
      check(bad_pulse, 0);
   endtask
   initial begin
      void'($urandom(56524));
      repeat (4) @(negedge clk);
      rst = 1'b0;
      start(1'b0);
      wait_idle();
      check(mfr, 8'h5a);
      check(dev, 8'ha7);
      run_prog(4'h1);
      run_prog(4'hb);
      run_prog(4'hc);
      print_verdict();
   end
endmodule
bind obp_sequencer obp_seq_monitor #(.PW_CYC(PW_CYC)) u_mon (.clk_sys_i, .sys_rst_i,
   .start_prog_i, .start_id_i, .addr_o, .data_pins_oe_o, .prog_strobe_n_o, .out_gate_n_o,
   .core_hi_o, .prog_hi_o, .prog_en_o, .id_mode_address_pin_o, .busy_o, .rd_valid_o);
`default_nettype wire
